//--- wdr_pkg.sv
// Purpose: shared constants and types of the watchdog supervisor
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes:   all offsets are byte addresses within the window
package wdr_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_RELOAD   = 8'h00;
   localparam logic [7:0] ADDR_IRQ_EN0   = 8'h04;
   localparam logic [7:0] ADDR_IRQ_EN1   = 8'h08;
   localparam logic [7:0] ADDR_IRQ_PRIO0 = 8'h0c;
   localparam logic [7:0] ADDR_CLKCTL   = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
   localparam logic [7:0] ADDR_COUNT    = 8'h1c;
   // Field positions
   localparam int PRESCALE_BIT = 7;
   localparam int ARM_BIT    = 6;
   localparam int COMMIT_BIT = 6;
   localparam int OWDS_BIT   = 7;
   localparam int WDTS_BIT   = 6;
   localparam int OPT_BIT    = 7;
   localparam int EV_TIMEOUT = 0;
   localparam int EV_REFRESH = 1;
   localparam int EV_EXPIRE  = 2;
   // Reset values
   localparam logic [7:0]  REG_RST   = 8'h00;
   localparam logic [14:0] COUNT_RST = 15'h0000;
   localparam logic [2:0]  EV_RST    = 3'h0;
   // Terminal count in counter steps, the rest in CPU clock cycles
   localparam logic [14:0] TERMINAL      = 15'h7ffc;
   localparam int          WINDOW_CYCLES = 12;
   localparam int          DIV_FAST      = 24;
   localparam int          DIV_SLOW      = 384;
   localparam int          RST_PULSE     = 4;
   // Watchdog states, one-hot
   typedef enum logic [2:0] {
      WDR_IDLE   = 3'b001,
      WDR_ACTIVE = 3'b010,
      WDR_FIRING = 3'b100
   } wdr_state_t;
   // Captured AHB address phase
   typedef struct packed {
      logic       sel;
      logic       write;
      logic [7:0] addr;
   } wdr_aphase_t;
endpackage

//--- wdr_watchdog.sv
// Purpose: watchdog supervisor with timed refresh and reset option
// Assumes: AHB-Lite slave, single word transfers, hclk at 125 MHz
// Notes:   cpu_rst is a pulse of RST_PULSE cycles; periph_rst pulses with it only under option 1
//
// Summary of operation
// - A 15-bit counter, a 7-bit reload value and control logic.
// - Hardware reset leaves the watchdog inactive, counter zero.
// - Only a software commit write starts the watchdog.
// - Once started it cannot be stopped except by hardware reset.
// - The counter steps every 24 or 384 clocks by prescale select.
// - At count 7ffc the watchdog raises its CPU reset.
// - A refresh counts only if commit comes within 12 of arm.
// - An arm not followed by commit in time lapses with no refresh.
// - A refresh loads the top seven counter bits from reload.
// - The arm bit clears itself 12 cycles after it was set.
// - Commit activates, refreshes if armed and not firing, self-clears after 12.
// - The read-only reset status is set at 7ffc, cleared after reset.
// - Option 1: watchdog reset also clears peripheral registers.
// - Option 0: peripheral registers survive a watchdog reset.
// - Priority register: bit 7 old status, bit 6 status, reset 0.
`timescale 1ns/100ps
module wdr_watchdog #(
   parameter int CNT_W = 15,
   parameter int PRE_W = 9
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   output logic             cpu_rst,
   output logic             periph_rst
);
   wdr_pkg::wdr_state_t   state;
   wdr_pkg::wdr_aphase_t  ap_q;
   logic [7:0]       reload;
   logic [7:0]       irq_en0;
   logic [7:0]       irq_en1;
   logic [5:0]       prio;
   logic             owds;
   logic             wdts;
   logic [7:0]       clkctl;
   logic [2:0]       irq_stat;
   logic [2:0]       irq_mask;
   logic [CNT_W-1:0] count;
   logic [PRE_W-1:0] pre_cnt;
   logic [3:0]       arm_cnt;
   logic [3:0]       commit_cnt;
   logic [2:0]       pulse_cnt;
   logic             wr_act;
   logic             rd_act;
   logic             commit_wr;
   logic             arm_wr;
   logic             refresh;
   logic             tick;
   logic             fire;
   logic             pulse_end;
   logic             opt_clear;
   logic             arm_lapse;
   logic [2:0]       events;
   logic [31:0]      next_rdata;

   // Bus decode; byte lanes ignored since only whole words are used
   assign wr_act    = ap_q.sel && ap_q.write;
   assign rd_act    = ap_q.sel && !ap_q.write && !hreadyout;
   assign arm_wr    = wr_act && ap_q.addr == wdr_pkg::ADDR_IRQ_EN0
                      && hwdata[wdr_pkg::ARM_BIT];
   assign commit_wr = wr_act && ap_q.addr == wdr_pkg::ADDR_IRQ_EN1
                      && hwdata[wdr_pkg::COMMIT_BIT];

   // Watchdog events
   assign refresh   = commit_wr && irq_en0[wdr_pkg::ARM_BIT]
                      && state != wdr_pkg::WDR_FIRING;
   assign arm_lapse = irq_en0[wdr_pkg::ARM_BIT] && arm_cnt == 4'd1
                      && !refresh;
   assign fire      = state == wdr_pkg::WDR_ACTIVE
                      && count == wdr_pkg::TERMINAL;
   assign pulse_end = state == wdr_pkg::WDR_FIRING
                      && pulse_cnt == 3'(wdr_pkg::RST_PULSE - 1);
   assign opt_clear = fire && clkctl[wdr_pkg::OPT_BIT];
   assign tick      = pre_cnt == (reload[wdr_pkg::PRESCALE_BIT]
                      ? PRE_W'(wdr_pkg::DIV_SLOW - 1)
                      : PRE_W'(wdr_pkg::DIV_FAST - 1));
   assign events[wdr_pkg::EV_TIMEOUT] = fire;
   assign events[wdr_pkg::EV_REFRESH] = refresh;
   assign events[wdr_pkg::EV_EXPIRE]  = arm_lapse;

   // Address phase capture, held while the slave stalls
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_q <= '0;
      end else if (hready) begin
         ap_q.sel   <= hsel && htrans[1];
         ap_q.write <= hwrite;
         ap_q.addr  <= haddr[7:0];
      end
   end

   // Reads take one wait state so a preceding write is always visible
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h00000000;
      end else begin
         hresp <= 1'b0;
         if (rd_act) begin
            hreadyout <= 1'b1;
            hrdata    <= next_rdata;
         end else if (hready && hsel && htrans[1] && !hwrite) begin
            hreadyout <= 1'b0;
         end
      end
   end

   // Read mux; unmapped offsets read as zero
   always_comb begin
      next_rdata = 32'h00000000;
      case (ap_q.addr)
         wdr_pkg::ADDR_RELOAD:   next_rdata[7:0] = reload;
         wdr_pkg::ADDR_IRQ_EN0:  next_rdata[7:0] = irq_en0;
         wdr_pkg::ADDR_IRQ_EN1:  next_rdata[7:0] = irq_en1;
         wdr_pkg::ADDR_IRQ_PRIO0: next_rdata[7:0] = {owds, wdts, prio};
         wdr_pkg::ADDR_CLKCTL:   next_rdata[7:0] = clkctl;
         wdr_pkg::ADDR_IRQ_STAT: next_rdata[2:0] = irq_stat;
         wdr_pkg::ADDR_IRQ_MASK: next_rdata[2:0] = irq_mask;
         wdr_pkg::ADDR_COUNT:    next_rdata[CNT_W-1:0] = count;
         default:                next_rdata = 32'h00000000;
      endcase
   end

   // Peripheral registers; wiped by a watchdog reset only under option
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reload <= wdr_pkg::REG_RST;
         prio   <= wdr_pkg::REG_RST[5:0];
      end else if (opt_clear) begin
         reload <= wdr_pkg::REG_RST;
         prio   <= wdr_pkg::REG_RST[5:0];
      end else if (wr_act) begin
         if (ap_q.addr == wdr_pkg::ADDR_RELOAD)
            reload <= hwdata[7:0];
         if (ap_q.addr == wdr_pkg::ADDR_IRQ_PRIO0)
            prio <= hwdata[5:0];
      end
   end

   // Clock control survives every watchdog reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clkctl <= wdr_pkg::REG_RST;
      end else if (wr_act && ap_q.addr == wdr_pkg::ADDR_CLKCTL) begin
         clkctl <= hwdata[7:0];
      end
   end

   // Enable registers; arm bit is set-only and times itself out
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_en0 <= wdr_pkg::REG_RST;
         arm_cnt <= 4'd0;
      end else begin
         if (opt_clear) begin
            irq_en0[5:0] <= wdr_pkg::REG_RST[5:0];
            irq_en0[7]   <= 1'b0;
         end else if (wr_act && ap_q.addr == wdr_pkg::ADDR_IRQ_EN0) begin
            irq_en0[5:0] <= hwdata[5:0];
            irq_en0[7]   <= hwdata[7];
         end
         if (refresh || arm_lapse) begin
            irq_en0[wdr_pkg::ARM_BIT] <= 1'b0;
            arm_cnt                   <= 4'd0;
         end else if (arm_wr && !irq_en0[wdr_pkg::ARM_BIT]) begin
            irq_en0[wdr_pkg::ARM_BIT] <= 1'b1;
            arm_cnt                   <= 4'(wdr_pkg::WINDOW_CYCLES);
         end else if (arm_cnt != 4'd0) begin
            arm_cnt <= arm_cnt - 4'd1;
         end
      end
   end

   // Commit bit lives 12 cycles; a rewrite while set does not extend it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_en1    <= wdr_pkg::REG_RST;
         commit_cnt <= 4'd0;
      end else begin
         if (opt_clear) begin
            irq_en1[5:0] <= wdr_pkg::REG_RST[5:0];
            irq_en1[7]   <= 1'b0;
         end else if (wr_act && ap_q.addr == wdr_pkg::ADDR_IRQ_EN1) begin
            irq_en1[5:0] <= hwdata[5:0];
            irq_en1[7]   <= hwdata[7];
         end
         if (commit_wr && !irq_en1[wdr_pkg::COMMIT_BIT]) begin
            irq_en1[wdr_pkg::COMMIT_BIT] <= 1'b1;
            commit_cnt <= 4'(wdr_pkg::WINDOW_CYCLES);
         end else if (commit_cnt == 4'd1) begin
            irq_en1[wdr_pkg::COMMIT_BIT] <= 1'b0;
            commit_cnt <= 4'd0;
         end else if (commit_cnt != 4'd0) begin
            commit_cnt <= commit_cnt - 4'd1;
         end
      end
   end

   // Watchdog state; no path leads back to idle but hardware reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= wdr_pkg::WDR_IDLE;
      end else begin
         case (state)
            wdr_pkg::WDR_IDLE:
               if (commit_wr) state <= wdr_pkg::WDR_ACTIVE;
            wdr_pkg::WDR_ACTIVE:
               if (fire) state <= wdr_pkg::WDR_FIRING;
            wdr_pkg::WDR_FIRING:
               if (pulse_end) state <= wdr_pkg::WDR_ACTIVE;
            default: state <= wdr_pkg::WDR_IDLE;
         endcase
      end
   end

   // Counter and prescaler; refresh restarts the low bits from zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count   <= wdr_pkg::COUNT_RST;
         pre_cnt <= '0;
      end else if (fire || state == wdr_pkg::WDR_FIRING) begin
         count   <= wdr_pkg::COUNT_RST;
         pre_cnt <= '0;
      end else if (refresh) begin
         count   <= {reload[6:0], 8'h00};
         pre_cnt <= '0;
      end else if (state == wdr_pkg::WDR_ACTIVE) begin
         pre_cnt <= tick ? '0 : pre_cnt + 1'b1;
         if (tick)
            count <= count + 1'b1;
      end
   end

   // Reset pulse and status bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_rst    <= 1'b0;
         periph_rst <= 1'b0;
         pulse_cnt  <= 3'd0;
         wdts       <= 1'b0;
         owds       <= 1'b0;
      end else if (fire) begin
         cpu_rst    <= 1'b1;
         periph_rst <= clkctl[wdr_pkg::OPT_BIT];
         pulse_cnt  <= 3'd0;
         wdts       <= 1'b1;
      end else if (pulse_end) begin
         cpu_rst    <= 1'b0;
         periph_rst <= 1'b0;
         wdts       <= 1'b0;
         owds       <= 1'b1;
      end else if (state == wdr_pkg::WDR_FIRING) begin
         pulse_cnt <= pulse_cnt + 3'd1;
      end
   end

   // Sticky events; a read clears, a same-cycle event still wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat <= wdr_pkg::EV_RST;
         irq_mask <= wdr_pkg::EV_RST;
         irq      <= 1'b0;
      end else begin
         if (rd_act && ap_q.addr == wdr_pkg::ADDR_IRQ_STAT)
            irq_stat <= events;
         else
            irq_stat <= irq_stat | events;
         if (wr_act && ap_q.addr == wdr_pkg::ADDR_IRQ_MASK)
            irq_mask <= hwdata[2:0];
         irq <= |(irq_stat & irq_mask);
      end
   end

   // Checker helpers; run lengths counted, long repeats unroll badly
   logic [3:0]       arm_age;
   logic [3:0]       commit_run;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         arm_age    <= 4'd0;
         commit_run <= 4'd0;
      end else begin
         arm_age    <= irq_en0[wdr_pkg::ARM_BIT] ? arm_age + 4'd1 : 4'd0;
         commit_run <= irq_en1[wdr_pkg::COMMIT_BIT]
                       ? commit_run + 4'd1 : 4'd0;
      end
   end

   // Checks
   sequence armed_s;
      $rose(irq_en0[wdr_pkg::ARM_BIT]);
   endsequence
   sequence committed_s;
      $rose(irq_en1[wdr_pkg::COMMIT_BIT]);
   endsequence

   arm_window_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      armed_s |-> ##[1:12] !irq_en0[wdr_pkg::ARM_BIT])
      else $error("arm bit outlived its window");
   commit_life_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      committed_s |-> ##12 (!irq_en1[wdr_pkg::COMMIT_BIT]
      && commit_run == 4'd12))
      else $error("commit bit did not last exactly 12 cycles");
   arm_lapse_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      irq_en0[wdr_pkg::ARM_BIT] && arm_age == 4'd11 && !commit_wr
      |=> irq_stat[wdr_pkg::EV_EXPIRE] && !irq_en0[wdr_pkg::ARM_BIT])
      else $error("lapsed arm not flagged");
   refresh_load_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      refresh && state == wdr_pkg::WDR_ACTIVE
      |=> count == {$past(reload[6:0]), 8'h00})
      else $error("refresh did not load reload value");
   start_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      state == wdr_pkg::WDR_IDLE && !commit_wr
      |=> state == wdr_pkg::WDR_IDLE)
      else $error("watchdog started without commit");
   no_stop_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      state != wdr_pkg::WDR_IDLE |=> state != wdr_pkg::WDR_IDLE)
      else $error("watchdog returned to idle");
   hold_rate_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      state == wdr_pkg::WDR_ACTIVE && !tick && !refresh && !fire
      |=> $stable(count))
      else $error("counter stepped without prescaler tick");
   fire_pulse_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      fire |=> (cpu_rst && wdts) [*4] ##1 (!cpu_rst && !wdts && owds))
      else $error("watchdog reset pulse wrong");
   opt_wipe_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      fire |=> (reload == wdr_pkg::REG_RST)
      == $past(clkctl[wdr_pkg::OPT_BIT]) || $past(reload) == reload)
      else $error("reset option not honoured");
   irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
      |(irq_stat & irq_mask) |=> irq)
      else $error("interrupt not raised");
endmodule

//--- tb_wdr_watchdog.sv
// Purpose: self-checking bench for the watchdog supervisor
// Assumes: AHB-Lite reads answer with one wait state, writes with none
// Notes:   read results are checked by a monitor against a queue of notes
`timescale 1ns/100ps
module tb_wdr_watchdog;
   logic        hclk, hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, irq, cpu_rst, periph_rst, rd_pend;
   logic [31:0] exp_q[$];
   logic [31:0] r;
   int          miscompares, n_tests;

   wdr_watchdog wdr_watchdog_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .irq(irq), .cpu_rst(cpu_rst),
      .periph_rst(periph_rst));

   // Free-running 125 MHz clock
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Monitor: a read ends at the edge where hreadyout is high again
   always @(posedge hclk) begin
      if (rd_pend && hreadyout === 1'b1) begin
         if (exp_q.size() == 0)
            chk("unexpected read", 32'h0, 32'hffffffff);
         else
            chk("read data", exp_q.pop_front(), hrdata);
         chk("hresp", 32'h0, {31'h0, hresp});
      end
      if (hreadyout === 1'b1)
         rd_pend <= hsel & htrans[1] & ~hwrite;
   end

   // Address phase held until accepted, then data phase until done
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(a, 1'b0, $urandom);
   endtask

   // Arm then commit back to back, well inside the window
   task automatic refresh();
      wr(wdr_pkg::ADDR_IRQ_EN0, 32'h40);
      wr(wdr_pkg::ADDR_IRQ_EN1, 32'h40);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Waits for the reset pulse, then measures its width
   task automatic await_rst(input logic per, input int lo, input int hi);
      int n;
      int w;
      n = 0;
      w = 0;
      while (cpu_rst !== 1'b1 && n < hi) begin
         @(posedge hclk);
         if (cpu_rst !== 1'b1) chk("periph idle", 32'h0, periph_rst);
         n++;
      end
      chk("timeout delay", 32'h1, {31'h0, n >= lo && n < hi});
      while (cpu_rst === 1'b1 && w < 8) begin
         chk("periph_rst", {31'h0, per}, {31'h0, periph_rst});
         @(posedge hclk);
         w++;
      end
      chk("pulse width", wdr_pkg::RST_PULSE, w);
   endtask

   // Reload 7f with 1/24: 252 steps of 24 cycles to the terminal count
   task automatic run_timeout(input logic opt);
      wr(wdr_pkg::ADDR_CLKCTL, opt ? 32'h80 : 32'h0);
      wr(wdr_pkg::ADDR_RELOAD, 32'h7f);
      wr(wdr_pkg::ADDR_IRQ_PRIO0, 32'h15);
      wr(wdr_pkg::ADDR_IRQ_MASK, 32'h01);
      wr(wdr_pkg::ADDR_IRQ_EN1, 32'h0);
      refresh();
      await_rst(opt, 6040, 6060);
      chk("irq timeout", 32'h1, {31'h0, irq});
      rd(wdr_pkg::ADDR_RELOAD, opt ? 32'h0 : 32'h7f);
      rd(wdr_pkg::ADDR_IRQ_PRIO0, opt ? 32'h80 : 32'h95);
      rd(wdr_pkg::ADDR_CLKCTL, opt ? 32'h80 : 32'h0);
      rd(wdr_pkg::ADDR_IRQ_STAT, 32'h03);
      wait_cyc(3);
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask

   // Cuts a hang short
   initial begin
      repeat (30000) @(posedge hclk);
      miscompares++;
      conclude();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      rd_pend = 1'b0;
      miscompares = 0;
      n_tests = 0;
      void'($urandom(10));
      wait_cyc(12);
      hresetn <= 1'b1;
      // Every register and two unmapped words read zero after reset
      for (int a = 0; a <= 36; a += 4) rd(a[7:0], 32'h0);
      r = $urandom;
      wr(wdr_pkg::ADDR_IRQ_PRIO0, {24'h0, 2'b11, r[5:0]});
      rd(wdr_pkg::ADDR_IRQ_PRIO0, {24'h0, 2'b00, r[5:0]});
      wr(wdr_pkg::ADDR_RELOAD, {24'h0, r[15:8]});
      rd(wdr_pkg::ADDR_RELOAD, {24'h0, r[15:8]});
      // An arm alone lapses and never starts the counter
      wr(wdr_pkg::ADDR_IRQ_EN0, 32'h40);
      rd(wdr_pkg::ADDR_IRQ_EN0, 32'h40);
      wait_cyc(14);
      rd(wdr_pkg::ADDR_IRQ_EN0, 32'h0);
      rd(wdr_pkg::ADDR_IRQ_STAT, 32'h04);
      wait_cyc(100);
      rd(wdr_pkg::ADDR_COUNT, 32'h0);
      // Slow prescaler, refresh event unmasked
      wr(wdr_pkg::ADDR_IRQ_MASK, 32'h02);
      wr(wdr_pkg::ADDR_RELOAD, 32'hc0);
      refresh();
      wait_cyc(2);
      chk("irq refresh", 32'h1, {31'h0, irq});
      rd(wdr_pkg::ADDR_COUNT, 32'h4000);
      rd(wdr_pkg::ADDR_IRQ_STAT, 32'h02);
      wait_cyc(3);
      chk("irq after clear", 32'h0, {31'h0, irq});
      wait_cyc(390);
      rd(wdr_pkg::ADDR_COUNT, 32'h4001);
      // Commit too late: no reload, masked lapse keeps irq low
      wr(wdr_pkg::ADDR_RELOAD, 32'h10);
      wr(wdr_pkg::ADDR_IRQ_EN0, 32'h40);
      wait_cyc(14);
      wr(wdr_pkg::ADDR_IRQ_EN1, 32'h40);
      chk("irq masked", 32'h0, {31'h0, irq});
      rd(wdr_pkg::ADDR_COUNT, 32'h4001);
      rd(wdr_pkg::ADDR_IRQ_STAT, 32'h04);
      // Only a hardware reset stops a running watchdog
      @(posedge hclk);
      hresetn <= 1'b0;
      wait_cyc(3);
      hresetn <= 1'b1;
      rd(wdr_pkg::ADDR_COUNT, 32'h0);
      wait_cyc(60);
      rd(wdr_pkg::ADDR_COUNT, 32'h0);
      run_timeout(1'b1);
      run_timeout(1'b0);
      wait_cyc(4);
      chk("queue drained", 32'h0, exp_q.size());
      conclude();
   end
endmodule
